// [bench/rfrc_host.sv]
`timescale 1ns/1ns

// system controller: register strobes and the two enable pins
module rfrc_host
(
   // clock
   input  wire logic       clk_sys_i,
   // register port toward the device
   output logic [7:0]      reg_addr_o,
   output logic            reg_wr_o,
   output logic [7:0]      reg_wdata_o,
   output logic            reg_rd_o,
   // enable pins
   output logic            sw_en_pin_o,
   output logic            chip_en_pin_o
);
   // idle levels at time zero
   initial
   begin
      reg_addr_o    = 8'h00;
      reg_wr_o      = 1'b0;
      reg_wdata_o   = 8'h00;
      reg_rd_o      = 1'b0;
      sw_en_pin_o   = 1'b1;
      chip_en_pin_o = 1'b1;
   end

   // one-cycle strobe; stale data inverted so nothing leans on it
   task automatic access(input logic w, input logic [7:0] a, d);
   begin
      @(posedge clk_sys_i);
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      reg_wr_o    <= w;
      reg_rd_o    <= !w;
      @(posedge clk_sys_i);
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
      reg_wdata_o <= ~d;
   end
   endtask

   // leaving latch-off needs a level change on one enable pin
   task automatic toggle(input logic chip);
   begin
      @(posedge clk_sys_i);
      if (chip)
         chip_en_pin_o <= !chip_en_pin_o;
      else
         sw_en_pin_o   <= !sw_en_pin_o;
   end
   endtask
endmodule

// [bench/rfrc_top_bench.sv]
`timescale 1ns/1ns

module rfrc_top_bench;
   // short hiccup delay keeps the run brief
   localparam int HIC    = 20;
   localparam int STP[4] = '{2, 4, 0, 1};

   logic       clk_sys_i        = 1'b0;
   logic       rst_n_i          = 1'b0;
   logic       global_resp_en_i = 1'b1;
   logic       ce               = 1'b1;
   logic [3:0] fault_cmp_i      = 4'h0;
   logic [1:0] mode_resp_i      = 2'h0;
   wire  [7:0] reg_addr;
   wire  [7:0] reg_wdata;
   wire        reg_wr;
   wire        reg_rd;
   wire        sw_en_pin;
   wire        chip_en_pin;
   logic [7:0] reg_rdata_o;
   logic       switch_en_o;
   logic       fault_flag_n_o;
   logic       fault_flag_oe_o;
   logic [7:0] exp_q[$];
   logic       rd_seen          = 1'b0;
   int         fails            = 0;
   int         n_compared       = 0;
   int         cycles           = 0;
   integer     seed             = 32'h3EDCDF04;

   // 125 MHz system clock
   initial
   begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   rfrc_top #(.HIC_CYCLES(HIC), .N_CHAN(4)) dut_u
   (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata_o),
      .global_resp_en_i(global_resp_en_i), .fault_cmp_i(fault_cmp_i),
      .mode_resp_i(mode_resp_i), .sw_en_pin_i(sw_en_pin),
      .chip_en_pin_i(chip_en_pin), .switch_en_o(switch_en_o),
      .fault_flag_n_o(fault_flag_n_o), .fault_flag_oe_o(fault_flag_oe_o)
   );

   rfrc_host host_u
   (
      .clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
      .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd),
      .sw_en_pin_o(sw_en_pin), .chip_en_pin_o(chip_en_pin)
   );

   task automatic check(input logic [7:0] seen, exp);
   begin
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   end
   endtask

   task automatic test_done;
   begin
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask

   // read data lands one cycle after the strobe is taken
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (rd_seen && exp_q.size() > 0)
         check(reg_rdata_o, exp_q.pop_front());
      rd_seen <= reg_rd;
      if (cycles == 6000)
      begin
         fails++;
         test_done();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   task automatic wr(input logic [7:0] a, d);
      host_u.access(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, e);
   begin
      exp_q.push_back(e);
      host_u.access(1'b0, a, 8'h00);
   end
   endtask

   // one fault on one channel under one control value
   task automatic fault_run(input int ch, code, input logic [7:0] ctl);
      logic stops;
   begin
      stops = (code == 1) || (code == 2);
      wr(8'hB3, ctl);
      fault_cmp_i[ch] <= 1'b1;
      cyc(6);
      check({fault_flag_oe_o, fault_flag_n_o}, 8'h02);
      check(switch_en_o, !stops);
      rd(8'hD3, 8'(1 << STP[ch]));
      fault_cmp_i[ch] <= 1'b0;
      if (code == 1)
      begin
         // a short refault must restart the restart delay
         cyc(10);
         fault_cmp_i[ch] <= 1'b1;
         cyc(2);
         fault_cmp_i[ch] <= 1'b0;
         cyc(HIC - 4);
         check(switch_en_o, 1'b0);
         cyc(12);
         check(switch_en_o, 1'b1);
      end
      else if (code == 2)
      begin
         cyc(HIC + 10);
         check(switch_en_o, 1'b0);
         host_u.toggle(ch[0]);
         cyc(6);
         check(switch_en_o, 1'b1);
      end
      // let the synced fault go before clearing, or set wins
      cyc(4);
      wr(8'hD3, 8'hFF);
      cyc(3);
      check({fault_flag_oe_o, fault_flag_n_o}, 8'h01);
      rd(8'hD3, 8'h00);
   end
   endtask

   // main sequence
   initial
   begin
      logic [7:0] v;
      cyc(16);
      rst_n_i <= 1'b1;
      rd(8'hB3, 8'h00);
      check({switch_en_o, fault_flag_n_o, fault_flag_oe_o}, 8'h06);
      rd(8'hD3, 8'h00);
      rd(8'h5C, 8'h00);
      wr(8'hB3, 8'hFF);
      rd(8'hB3, 8'hFF);
      for (int i = 0; i < 6; i++)
      begin
         v = $random(seed);
         wr(8'hB3, v);
         rd(8'hB3, v);
      end
      for (int ch = 0; ch < 4; ch++)
         for (int c = 0; c < 4; c++)
            fault_run(ch, c, 8'(c << (2 * ch)));
      // enable low: the mode pins decide, fields ignored
      global_resp_en_i <= 1'b0;
      mode_resp_i      <= 2'h2;
      fault_run(0, 2, 8'h55);
      mode_resp_i      <= 2'h0;
      fault_run(1, 0, 8'hAA);
      // enable low freezes the bank: this write must not land
      ce <= 1'b0;
      wr(8'hB3, 8'h3C);
      ce <= 1'b1;
      rd(8'hB3, 8'hAA);
      cyc(4);
      test_done();
   end
endmodule

// [inc/rfrc_map.svh]
`ifndef RFRC_MAP_SVH
`define RFRC_MAP_SVH

// register addresses on the management port
`define RFRC_CTRL_ADDR   8'hB3
`define RFRC_STAT_ADDR   8'hD3

// reset values
`define RFRC_CTRL_RST    8'h00
`define RFRC_STAT_RST    8'h00

// response field positions in the control register
`define RFRC_GD_OV_LSB   0
`define RFRC_GD_UV_LSB   2
`define RFRC_BI_OV_LSB   4
`define RFRC_BI_UV_LSB   6
`define RFRC_FIELD_W     2

// fault status bit positions in the second status register
`define RFRC_ST_GD_OV    2
`define RFRC_ST_GD_UV    4
`define RFRC_ST_BI_OV    0
`define RFRC_ST_BI_UV    1

// hiccup restart delay, in ms, and the cycles it takes
`define RFRC_HICCUP_MS   500
`define RFRC_CLK_KHZ     125000
`define RFRC_HICCUP_CYC  (`RFRC_HICCUP_MS * `RFRC_CLK_KHZ)

`endif

// [inc/rfrc_pkg.sv]
package rfrc_pkg;

   // response codes of one two-bit field
   typedef enum logic [1:0] {
      RESP_FLAG     = 2'h0,
      RESP_HICCUP   = 2'h1,
      RESP_LATCH    = 2'h2,
      RESP_FLAG_ALT = 2'h3
   } rfrc_resp_type;

   // per-channel response state, one-hot
   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_HIC = 3'h2,
      ST_LAT = 3'h4
   } rfrc_chan_st_type;

   // full state of one response channel
   typedef struct packed {
      rfrc_chan_st_type st;
      logic [31:0]      cnt;
   } rfrc_chan_state_type;

   // full state of the register bank top
   typedef struct packed {
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [1:0] en_prev;
      logic [7:0] ctrl;
      logic [7:0] status;
      logic [7:0] rdata;
      logic       sw_en;
      logic       flag_n;
      logic       flag_oe;
   } rfrc_top_state_type;

endpackage

// [src/rfrc_chan.sv]
`timescale 1ns/1ns
`include "rfrc_map.svh"

module rfrc_chan
   import rfrc_pkg::*;
#(
   parameter int HIC_CYCLES = `RFRC_HICCUP_CYC
)
(
   // clock, reset, enable
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   // fault and selected response
   input  wire logic             fault_i,
   input  wire rfrc_resp_type    code_i,
   input  wire logic             clr_latch_i,
   // switching stop request
   output logic                  stop_o
);

   rfrc_chan_state_type r;
   rfrc_chan_state_type next_r;

   localparam logic [31:0] HIC_LAST = 32'(HIC_CYCLES - 1);

   // response sequencing
   always_comb
   begin
      next_r = r;
      if (ce_i)
      begin
         case (r.st)
            ST_RUN:
            begin
               // flag-only codes leave switching alone
               if (fault_i && code_i == RESP_HICCUP)
               begin
                  next_r.st  = ST_HIC;
                  next_r.cnt = 32'h0;
               end
               else if (fault_i && code_i == RESP_LATCH)
                  next_r.st = ST_LAT;
            end
            ST_HIC:
            begin
               // delay counts only once the fault has gone
               if (fault_i)
                  next_r.cnt = 32'h0;
               else if (r.cnt == HIC_LAST)
               begin
                  next_r.st  = ST_RUN;
                  next_r.cnt = 32'h0;
               end
               else
                  next_r.cnt = r.cnt + 32'h1;
            end
            ST_LAT:
            begin
               // only a toggle of an enable pin releases it
               if (clr_latch_i)
                  next_r.st = ST_RUN;
            end
            default:
               next_r.st = ST_RUN;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         r.st  <= ST_RUN;
         r.cnt <= 32'h0;
      end
      else
         r <= next_r;
   end

   assign stop_o = (r.st != ST_RUN);

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence hic_expire;
      ce_i && r.st == ST_HIC && !fault_i && r.cnt == HIC_LAST;
   endsequence

   AST_FLAG_ONLY: assert property (
      ce_i && r.st == ST_RUN &&
      (code_i == RESP_FLAG || code_i == RESP_FLAG_ALT) |=> r.st == ST_RUN)
      else $error("flag-only code left the run state");

   AST_HIC_ENTER: assert property (
      ce_i && r.st == ST_RUN && fault_i && code_i == RESP_HICCUP
      |=> r.st == ST_HIC && r.cnt == 32'h0 && stop_o)
      else $error("hiccup not entered on fault");

   AST_HIC_EXPIRE: assert property (hic_expire |=> r.st == ST_RUN)
      else $error("hiccup did not restart after the delay");

   AST_HIC_RESTART: assert property (
      ce_i && r.st == ST_HIC && fault_i |=> r.st == ST_HIC && r.cnt == 32'h0)
      else $error("hiccup delay not restarted by fault");

   AST_LATCH_HOLD: assert property (
      ce_i && r.st == ST_LAT && !clr_latch_i |=> r.st == ST_LAT && stop_o)
      else $error("latch-off released without enable toggle");

endmodule

// [src/rfrc_top.sv]
// Summary of operation
// - control register is one byte, fully read/write, reset to zero.
// - bits 1:0 select the gate-drive rail overvoltage response.
// - bits 3:2 select the gate-drive rail undervoltage response.
// - bits 5:4 and 7:6 select bias rail over/undervoltage responses.
// - fields apply only when the global individual-response enable is set.
// - with global enable clear, the mode pin setting picks the response.
// - gate-drive overvoltage sets status bit 2 and pulls the flag low.
// - gate-drive undervoltage sets status bit 4 and pulls the flag low.
// - code 00 only records and flags; switching keeps running.
// - code 01 stops switching, restarts 500 ms after the fault clears.
// - code 10 stops switching and never restarts by itself.
// - code 11 behaves exactly like code 00.
`timescale 1ns/1ns
`include "rfrc_map.svh"

module rfrc_top
   import rfrc_pkg::*;
#(
   parameter int HIC_CYCLES = `RFRC_HICCUP_CYC,
   parameter int N_CHAN     = 4
)
(
   // clock, reset, enable
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   // register port from the management interface
   input  wire logic [7:0]       reg_addr_i,
   input  wire logic             reg_wr_i,
   input  wire logic [7:0]       reg_wdata_i,
   input  wire logic             reg_rd_i,
   output logic [7:0]            reg_rdata_o,
   // global individual-response enable from the general control reg
   input  wire logic             global_resp_en_i,
   // asynchronous pins: comparators, mode setting, enables
   input  wire logic [N_CHAN-1:0] fault_cmp_i,
   input  wire logic [1:0]       mode_resp_i,
   input  wire logic             sw_en_pin_i,
   input  wire logic             chip_en_pin_i,
   // converter switching permission
   output logic                  switch_en_o,
   // open-drain fault flag
   output logic                  fault_flag_n_o,
   output logic                  fault_flag_oe_o
);

   // sync vector layout
   localparam int SY_MODE = N_CHAN;
   localparam int SY_SW   = N_CHAN + 2;
   localparam int SY_CE   = N_CHAN + 3;

   rfrc_top_state_type r;
   rfrc_top_state_type next_r;

   rfrc_resp_type     code_w [N_CHAN];
   logic [N_CHAN-1:0] stop_w;
   logic [N_CHAN-1:0] fault_w;
   logic              toggle_w;
   logic [7:0]        set_w;

   // status bit that each channel reports into
   function automatic int stat_bit(input int ch);
      case (ch)
         0:       stat_bit = `RFRC_ST_GD_OV;
         1:       stat_bit = `RFRC_ST_GD_UV;
         2:       stat_bit = `RFRC_ST_BI_OV;
         default: stat_bit = `RFRC_ST_BI_UV;
      endcase
   endfunction

   // lsb of each channel's field in the control register
   function automatic int field_lsb(input int ch);
      case (ch)
         0:       field_lsb = `RFRC_GD_OV_LSB;
         1:       field_lsb = `RFRC_GD_UV_LSB;
         2:       field_lsb = `RFRC_BI_OV_LSB;
         default: field_lsb = `RFRC_BI_UV_LSB;
      endcase
   endfunction

   // comparators read only after the second sync stage
   assign fault_w  = r.sync2[N_CHAN-1:0];
   // either enable pin changing level releases latch-off
   assign toggle_w = (r.sync2[SY_CE:SY_SW] != r.en_prev);

   genvar gi;
   generate
      for (gi = 0; gi < N_CHAN; gi++)
      begin : g_chan
         // register field or mode pin, as the global enable decides
         assign code_w[gi] = global_resp_en_i
            ? rfrc_resp_type'(r.ctrl[field_lsb(gi) +: `RFRC_FIELD_W])
            : rfrc_resp_type'(r.sync2[SY_MODE +: 2]);
         // every response code records the fault
         assign set_w[stat_bit(gi)] = fault_w[gi];

         rfrc_chan #(
            .HIC_CYCLES (HIC_CYCLES)
         ) u_chan (
            .clk_sys_i   (clk_sys_i),
            .rst_n_i     (rst_n_i),
            .ce_i        (ce_i),
            .fault_i     (fault_w[gi]),
            .code_i      (code_w[gi]),
            .clr_latch_i (toggle_w),
            .stop_o      (stop_w[gi])
         );
      end
      // unused status positions never set
      for (gi = 0; gi < 8; gi++)
      begin : g_unused
         if (gi != `RFRC_ST_GD_OV && gi != `RFRC_ST_GD_UV &&
             gi != `RFRC_ST_BI_OV && gi != `RFRC_ST_BI_UV)
         begin : g_zero
            assign set_w[gi] = 1'b0;
         end
      end
   endgenerate

   // register bank and outputs
   always_comb
   begin
      next_r = r;
      if (ce_i)
      begin
         // two-stage synchroniser on every pin input
         next_r.sync1   = {chip_en_pin_i, sw_en_pin_i, mode_resp_i,
                           fault_cmp_i};
         next_r.sync2   = r.sync1;
         next_r.en_prev = r.sync2[SY_CE:SY_SW];
         // control byte takes every bit written
         if (reg_wr_i && reg_addr_i == `RFRC_CTRL_ADDR)
            next_r.ctrl = reg_wdata_i;
         // write one to clear; a fault in the same cycle still sets
         if (reg_wr_i && reg_addr_i == `RFRC_STAT_ADDR)
            next_r.status = (r.status & ~reg_wdata_i) | set_w;
         else
            next_r.status = r.status | set_w;
         // read data; unmapped addresses answer zero
         if (reg_rd_i)
         begin
            if (reg_addr_i == `RFRC_CTRL_ADDR)
               next_r.rdata = r.ctrl;
            else if (reg_addr_i == `RFRC_STAT_ADDR)
               next_r.rdata = r.status;
            else
               next_r.rdata = 8'h00;
         end
         // any channel in hiccup or latch-off stops switching
         next_r.sw_en   = ~|stop_w;
         // flag pulled low while any fault is on record
         next_r.flag_oe = |r.status;
         next_r.flag_n  = ~|r.status;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         // enable pins idle high; matching levels avoid a false toggle
         r.sync1   <= 8'hC0;
         r.sync2   <= 8'hC0;
         r.en_prev <= 2'h3;
         r.ctrl    <= `RFRC_CTRL_RST;
         r.status  <= `RFRC_STAT_RST;
         r.rdata   <= 8'h00;
         r.sw_en   <= 1'b1;
         r.flag_n  <= 1'b1;
         r.flag_oe <= 1'b0;
      end
      else
         r <= next_r;
   end

   // all outputs are flops of the state
   assign reg_rdata_o     = r.rdata;
   assign switch_en_o     = r.sw_en;
   assign fault_flag_n_o  = r.flag_n;
   assign fault_flag_oe_o = r.flag_oe;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence ctrl_write;
      ce_i && reg_wr_i && reg_addr_i == `RFRC_CTRL_ADDR;
   endsequence

   sequence ctrl_read;
      ce_i && reg_rd_i && reg_addr_i == `RFRC_CTRL_ADDR && !reg_wr_i;
   endsequence

   AST_CTRL_RW: assert property (
      ctrl_write ##1 (ce_i && !reg_wr_i) ##1 ctrl_read
      |=> reg_rdata_o == $past(reg_wdata_i, 3))
      else $error("control byte did not read back as written");

   AST_GD_OV_FIELD: assert property (
      global_resp_en_i |-> code_w[0] == rfrc_resp_type'(r.ctrl[1:0]))
      else $error("overvoltage response not from bits 1:0");

   AST_GD_UV_FIELD: assert property (
      global_resp_en_i |-> code_w[1] == rfrc_resp_type'(r.ctrl[3:2]))
      else $error("undervoltage response not from bits 3:2");

   AST_BIAS_FIELD: assert property (
      global_resp_en_i |-> code_w[2] == rfrc_resp_type'(r.ctrl[5:4]) &&
                           code_w[3] == rfrc_resp_type'(r.ctrl[7:6]))
      else $error("bias responses not from bits 7:4");

   AST_MODE_PIN: assert property (
      !global_resp_en_i |->
         code_w[0] == rfrc_resp_type'(r.sync2[SY_MODE +: 2]))
      else $error("mode pin not used with global enable clear");

   AST_GD_OV_STATUS: assert property (
      ce_i && fault_w[0] |=> r.status[`RFRC_ST_GD_OV])
      else $error("overvoltage status bit not set");

   AST_GD_UV_STATUS: assert property (
      ce_i && fault_w[1] |=> r.status[`RFRC_ST_GD_UV])
      else $error("undervoltage status bit not set");

   AST_FLAG_LOW: assert property (
      ce_i && fault_w[0] ##1 ce_i |=> fault_flag_oe_o && !fault_flag_n_o)
      else $error("fault flag not pulled low");

   AST_FLAG_ONLY_RUNS: assert property (
      ce_i && stop_w == '0 |=> switch_en_o)
      else $error("switching stopped without a stopping response");

   AST_STOP_SWITCH: assert property (
      ce_i && stop_w != '0 |=> !switch_en_o)
      else $error("switching not stopped");

endmodule
